// *** core/timer16_counter_capture.v ***
// Overview of operation
// - timer tick is cpu clock divided by 2, 4 or 8 per clock-select bits
// - both clock-select bits set selects the external clock pin
// - external-edge select bit picks which external transition advances counter
// - external counting syncs to cpu falling edge; source spaces edges four apart
// - writing either counter low byte reloads counter with FFFC
// - reset value of counter is FFFC, the only reload value
// - alternate counter view, its low write reloads; its low read never clears overflow
// - high byte read buffers low byte until low byte is read
// - lone low byte read after complete sequence returns live low byte
// - counter wrap from FFFF to 0000 sets overflow flag in every mode
// - overflow interrupt only with enable and global permission; stays pending
// - overflow clears after status read with flag set then main low access
// - counter runs in wait, freezes in halt, resumes held count
// - active capture edge copies counter into capture register, sets flag
// - channel two edge bit in control two, channel one in control one
// - one capture enable requests interrupt for either channel, pending otherwise
// - capture flag clears after status read then its low byte access
// - capture high read blocks captures and flag until low byte read
// - capture registers read-only, hold latest captured count
// - in one-pulse or pwm operation only capture channel two captures
// - capture pins always feed capture logic, even when driven as output
// - unbonded timer input reads as logic one
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "timer16_consts.vh"
module timer16_counter_capture #(
   parameter EXT_CLK_BONDED = 1,
   parameter CAP_ONE_BONDED = 1,
   parameter CAP_TWO_BONDED = 1
) (
   input wire clk_i,
   input wire rstn_i,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire ext_timer_clock_pin_i,
   input wire capture_pin_one_i,
   input wire capture_pin_two_i,
   input wire global_irq_permit_i,
   input wire halt_mode_i,
   output wire timer_irq_o
);

////////////////////////////////////////////////////////////////////////////////
// pin conditioning
// an unbonded capture pin idles high like its edge register, so it never captures
wire ext_pin = EXT_CLK_BONDED ? ext_timer_clock_pin_i : 1'b1;
wire cap1_pin = CAP_ONE_BONDED ? capture_pin_one_i : 1'b1;
wire cap2_pin = CAP_TWO_BONDED ? capture_pin_two_i : 1'b1;

reg [7:0] control_reg_one;
reg [7:0] control_reg_two;
reg [15:0] count_value;
reg [7:0] low_buf_reg;
reg low_held_reg;
reg [15:0] cap1_reg;
reg [15:0] cap2_reg;
reg cap1_block_reg;
reg cap2_block_reg;
reg overflow_flag;
reg capture_flag_one;
reg capture_flag_two;
reg ovf_armed_reg;
reg cap1_armed_reg;
reg cap2_armed_reg;

wire [1:0] timer_clock_select = {control_reg_two[`T16_C2_CLK_SEL_HI],
   control_reg_two[`T16_C2_CLK_SEL_LO]};
wire ext_edge_select = control_reg_two[`T16_C2_EXT_EDGE];
wire capture_edge_one = control_reg_one[`T16_C1_CAPTURE_EDGE_ONE];
wire capture_edge_two = control_reg_two[`T16_C2_CAPTURE_EDGE_TWO];
wire one_pulse_operation = control_reg_two[`T16_C2_ONE_PULSE] |
   control_reg_two[`T16_C2_PWM];

////////////////////////////////////////////////////////////////////////////////
// bus handshake: write taken when address and data both present
// address and data may arrive in either order; each is parked until its partner
reg aw_held_reg;
reg w_held_reg;
reg [7:0] aw_addr_reg;
reg [31:0] w_data_reg;
assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
wire aw_now = aw_held_reg | (s_axi_awvalid & s_axi_awready);
wire w_now = w_held_reg | (s_axi_wvalid & s_axi_wready);
wire [7:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
wire wr_fire = aw_now & w_now & !s_axi_bvalid;
wire wr_lane0 = w_held_reg ? 1'b1 : s_axi_wstrb[0];
reg wr_strb0_reg;
// a write without lane 0 is answered but changes nothing
wire wr_en = wr_fire & (w_held_reg ? wr_strb0_reg : wr_lane0);
assign s_axi_arready = !s_axi_rvalid;
wire rd_fire = s_axi_arvalid & s_axi_arready;
wire [7:0] rd_addr = s_axi_araddr;

// misaligned or past the last register: refused with slverr
function addr_known;
   input [7:0] a;
   begin
      addr_known = (a[1:0] == 2'b00) && (a <= `T16_ADDR_PINS);
   end
endfunction

// one-cycle strobe on the transition picked by the select bit
function edge_hit;
   input rising_sel;
   input now_lvl;
   input was_lvl;
   begin
      edge_hit = rising_sel ? (now_lvl & !was_lvl) : (!now_lvl & was_lvl);
   end
endfunction

always @(posedge clk_i or negedge rstn_i) begin
   if (!rstn_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      wr_strb0_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
   end else begin
      if (wr_fire) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_known(wr_addr) ? 2'b00 : 2'b10;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            wr_strb0_reg <= s_axi_wstrb[0];
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// access strobes
wire wr_c1 = wr_en && wr_addr == `T16_ADDR_CTRL_ONE;
wire wr_c2 = wr_en && wr_addr == `T16_ADDR_CTRL_TWO;
wire wr_cnt_lo = wr_en && wr_addr == `T16_ADDR_CNT_LO;
wire wr_acnt_lo = wr_en && wr_addr == `T16_ADDR_ACNT_LO;
wire wr_cap1_lo = wr_en && wr_addr == `T16_ADDR_CAP1_LO;
wire wr_cap2_lo = wr_en && wr_addr == `T16_ADDR_CAP2_LO;
wire rd_sr = rd_fire && rd_addr == `T16_ADDR_STATUS;
// either high view opens the shared low-byte buffer
wire rd_cnt_hi = rd_fire && (rd_addr == `T16_ADDR_CNT_HI || rd_addr == `T16_ADDR_ACNT_HI);
wire rd_cnt_lo = rd_fire && rd_addr == `T16_ADDR_CNT_LO;
wire rd_any_lo = rd_fire && (rd_addr == `T16_ADDR_CNT_LO || rd_addr == `T16_ADDR_ACNT_LO);
wire rd_cap1_hi = rd_fire && rd_addr == `T16_ADDR_CAP1_HI;
wire rd_cap1_lo = rd_fire && rd_addr == `T16_ADDR_CAP1_LO;
wire rd_cap2_hi = rd_fire && rd_addr == `T16_ADDR_CAP2_HI;
wire rd_cap2_lo = rd_fire && rd_addr == `T16_ADDR_CAP2_LO;

////////////////////////////////////////////////////////////////////////////////
// prescaler as enable pulses, no derived clock
// divider restarts on reload and halt, so each new period is a full one
reg [2:0] presc_reg;
wire [3:0] div_sel = (timer_clock_select == 2'b00) ? `T16_DIV2 :
   (timer_clock_select == 2'b01) ? `T16_DIV4 : `T16_DIV8;
wire presc_tick = (presc_reg == div_sel[2:0] - 3'd1) ||
   (div_sel == `T16_DIV8 && presc_reg == 3'd7);
wire use_ext = (timer_clock_select == 2'b11);

// external pin sampled on falling cpu edge, then edge detected
reg ext_fall_reg;
reg ext_s1_reg;
reg ext_s2_reg;
reg [2:0] ext_gap_reg;
always @(negedge clk_i or negedge rstn_i) begin
   if (!rstn_i)
      ext_fall_reg <= 1'b0;
   else
      ext_fall_reg <= ext_pin;
end
wire ext_edge = edge_hit(ext_edge_select, ext_s1_reg, ext_s2_reg);
// edges closer than the minimum spacing are dropped rather than double counted
wire ext_tick = ext_edge && (ext_gap_reg >= `T16_EXT_MIN_EDGES - 3'd1);

// wait mode needs no input: the counter simply keeps running
wire run = !halt_mode_i;
wire tick = run && (use_ext ? ext_tick : presc_tick);
wire reload = wr_cnt_lo | wr_acnt_lo;

always @(posedge clk_i or negedge rstn_i) begin
   if (!rstn_i) begin
      presc_reg <= 3'd0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_gap_reg <= 3'd0;
      count_value <= `T16_RELOAD_VALUE;
   end else begin
      ext_s1_reg <= ext_fall_reg;
      ext_s2_reg <= ext_s1_reg;
      if (ext_edge)
         ext_gap_reg <= 3'd0;
      else if (ext_gap_reg != 3'd7)
         ext_gap_reg <= ext_gap_reg + 3'd1;
      if (reload || !run || presc_tick)
         presc_reg <= 3'd0;
      else
         presc_reg <= presc_reg + 3'd1;
      if (reload)
         count_value <= `T16_RELOAD_VALUE;
      else if (tick)
         count_value <= count_value + 16'h0001;
   end
end
wire wrap = tick && !reload && (count_value == 16'hFFFF);

////////////////////////////////////////////////////////////////////////////////
// capture edges; pins sampled regardless of pin direction
reg cap1_d_reg;
reg cap2_d_reg;
wire cap1_edge = edge_hit(capture_edge_one, cap1_pin, cap1_d_reg);
wire cap2_edge = edge_hit(capture_edge_two, cap2_pin, cap2_d_reg);
// one-pulse and pwm own channel one's pin, so only channel two may capture
wire cap1_allowed = !cap1_block_reg && !one_pulse_operation;
wire cap2_allowed = !cap2_block_reg;
wire cap1_go = cap1_edge && cap1_allowed;
wire cap2_go = cap2_edge && cap2_allowed;

////////////////////////////////////////////////////////////////////////////////
// registers, flags, two-step clears
always @(posedge clk_i or negedge rstn_i) begin
   if (!rstn_i) begin
      control_reg_one <= 8'h00;
      control_reg_two <= 8'h00;
      low_buf_reg <= 8'h00;
      low_held_reg <= 1'b0;
      cap1_reg <= 16'h0000;
      cap2_reg <= 16'h0000;
      cap1_block_reg <= 1'b0;
      cap2_block_reg <= 1'b0;
      overflow_flag <= 1'b0;
      capture_flag_one <= 1'b0;
      capture_flag_two <= 1'b0;
      ovf_armed_reg <= 1'b0;
      cap1_armed_reg <= 1'b0;
      cap2_armed_reg <= 1'b0;
      cap1_d_reg <= 1'b1;
      cap2_d_reg <= 1'b1;
   end else begin
      cap1_d_reg <= cap1_pin;
      cap2_d_reg <= cap2_pin;
      if (wr_c1)
         control_reg_one <= wr_data[7:0];
      if (wr_c2)
         control_reg_two <= wr_data[7:0];
      // first high read fixes buffer; repeats leave it alone
      if (rd_cnt_hi && !low_held_reg) begin
         low_buf_reg <= count_value[7:0];
         low_held_reg <= 1'b1;
      end else if (rd_any_lo) begin
         low_held_reg <= 1'b0;
      end
      // status read arms clear; the set always beats the clear
      if (rd_sr)
         ovf_armed_reg <= overflow_flag;
      else if (rd_cnt_lo || wr_cnt_lo)
         ovf_armed_reg <= 1'b0;
      if (wrap)
         overflow_flag <= 1'b1;
      else if (ovf_armed_reg && (rd_cnt_lo || wr_cnt_lo))
         overflow_flag <= 1'b0;
      if (rd_sr)
         cap1_armed_reg <= capture_flag_one;
      else if (rd_cap1_lo || wr_cap1_lo)
         cap1_armed_reg <= 1'b0;
      if (rd_sr)
         cap2_armed_reg <= capture_flag_two;
      else if (rd_cap2_lo || wr_cap2_lo)
         cap2_armed_reg <= 1'b0;
      if (rd_cap1_hi)
         cap1_block_reg <= 1'b1;
      else if (rd_cap1_lo)
         cap1_block_reg <= 1'b0;
      if (rd_cap2_hi)
         cap2_block_reg <= 1'b1;
      else if (rd_cap2_lo)
         cap2_block_reg <= 1'b0;
      if (cap1_go) begin
         cap1_reg <= count_value;
         capture_flag_one <= 1'b1;
      end else if (cap1_armed_reg && (rd_cap1_lo || wr_cap1_lo)) begin
         capture_flag_one <= 1'b0;
      end
      if (cap2_go) begin
         cap2_reg <= count_value;
         capture_flag_two <= 1'b1;
      end else if (cap2_armed_reg && (rd_cap2_lo || wr_cap2_lo)) begin
         capture_flag_two <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt request: pending flags gated by enables and global permission
// flags stay set while masked, so the request appears once permission returns
wire ovf_pending = control_reg_one[`T16_C1_OVERFLOW_IRQ_EN] && overflow_flag;
wire cap_pending = control_reg_one[`T16_C1_CAPTURE_IRQ_EN] &&
   (capture_flag_one || capture_flag_two);
assign timer_irq_o = global_irq_permit_i && (ovf_pending || cap_pending);

////////////////////////////////////////////////////////////////////////////////
// read data
reg [7:0] status_byte;
always @* begin
   status_byte = 8'h00;
   status_byte[`T16_SR_CAPTURE_ONE] = capture_flag_one;
   status_byte[`T16_SR_OVERFLOW] = overflow_flag;
   status_byte[`T16_SR_CAPTURE_TWO] = capture_flag_two;
end

// byte latched at the taking edge, so later counting cannot tear it
reg [7:0] rd_byte;
always @* begin
   case (rd_addr)
      `T16_ADDR_CTRL_ONE: rd_byte = control_reg_one;
      `T16_ADDR_CTRL_TWO: rd_byte = control_reg_two;
      `T16_ADDR_STATUS: rd_byte = status_byte;
      `T16_ADDR_CNT_HI: rd_byte = count_value[15:8];
      `T16_ADDR_ACNT_HI: rd_byte = count_value[15:8];
      `T16_ADDR_CNT_LO: rd_byte = low_held_reg ? low_buf_reg : count_value[7:0];
      `T16_ADDR_ACNT_LO: rd_byte = low_held_reg ? low_buf_reg : count_value[7:0];
      `T16_ADDR_CAP1_HI: rd_byte = cap1_reg[15:8];
      `T16_ADDR_CAP1_LO: rd_byte = cap1_reg[7:0];
      `T16_ADDR_CAP2_HI: rd_byte = cap2_reg[15:8];
      `T16_ADDR_CAP2_LO: rd_byte = cap2_reg[7:0];
      `T16_ADDR_PINS: rd_byte = {5'h00, ext_pin, cap2_pin, cap1_pin};
      default: rd_byte = 8'h00;
   endcase
end

always @(posedge clk_i or negedge rstn_i) begin
   if (!rstn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
   end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= addr_known(rd_addr) ? 2'b00 : 2'b10;
   end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
   end
end

endmodule // timer16_counter_capture

// *** core/timer16_consts.vh ***
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
// register byte addresses (one aligned word each)
`define T16_ADDR_CTRL_ONE 8'h00
`define T16_ADDR_CTRL_TWO 8'h04
`define T16_ADDR_STATUS 8'h08
`define T16_ADDR_CNT_HI 8'h0C
`define T16_ADDR_CNT_LO 8'h10
`define T16_ADDR_ACNT_HI 8'h14
`define T16_ADDR_ACNT_LO 8'h18
`define T16_ADDR_CAP1_HI 8'h1C
`define T16_ADDR_CAP1_LO 8'h20
`define T16_ADDR_CAP2_HI 8'h24
`define T16_ADDR_CAP2_LO 8'h28
`define T16_ADDR_PINS 8'h2C
// control_reg_one fields
`define T16_C1_CAPTURE_IRQ_EN 7
`define T16_C1_OVERFLOW_IRQ_EN 5
`define T16_C1_CAPTURE_EDGE_ONE 1
// control_reg_two fields
`define T16_C2_ONE_PULSE 4
`define T16_C2_PWM 3
`define T16_C2_CLK_SEL_HI 2
`define T16_C2_CLK_SEL_LO 1
`define T16_C2_EXT_EDGE 0
`define T16_C2_CAPTURE_EDGE_TWO 5
// status fields
`define T16_SR_CAPTURE_ONE 7
`define T16_SR_CAPTURE_TWO 4
`define T16_SR_OVERFLOW 5
// counter reload / reset value
`define T16_RELOAD_VALUE 16'hFFFC
// prescaler divide ratios
`define T16_DIV2 4'h2
`define T16_DIV4 4'h4
`define T16_DIV8 4'h8
// least falling cpu edges between external active edges
`define T16_EXT_MIN_EDGES 3'h4
`endif

// *** verification/timer16_counter_capture_assertions.sv ***
`timescale 1ns/1ns
module timer16_counter_capture_assertions (
   input wire clk_i,
   input wire rstn_i,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire global_irq_permit_i,
   input wire timer_irq_o
);
   wire w_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire r_t = s_axi_arvalid && s_axi_arready;
   // misaligned counts as unmapped
   wire r_bad = r_t && (s_axi_araddr > 8'h2C || s_axi_araddr[1:0] != 2'b00);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   //////////////////////////////////////////////////
   AST_B_AFTER: assert property (w_t |=> s_axi_bvalid)
      else $error("write response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_AFTER: assert property (r_t |=> s_axi_rvalid)
      else $error("read response late");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped early");
   AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_RD_ERR: assert property (r_bad |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   AST_RD_BYTE: assert property (r_t && !r_bad |=> s_axi_rresp == 2'b00 && s_axi_rdata[31:8] == 24'h0)
      else $error("mapped read not a clean byte");
   AST_IRQ_MASK: assert property (!global_irq_permit_i |-> !timer_irq_o)
      else $error("interrupt without permission");
   cover property (w_t);
   cover property (r_bad);
   cover property (timer_irq_o);
endmodule // timer16_counter_capture_assertions

bind timer16_counter_capture timer16_counter_capture_assertions chk_u (
   .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .global_irq_permit_i(global_irq_permit_i),
   .timer_irq_o(timer_irq_o)
);

// *** verification/timer_pin_source.sv ***
`timescale 1ns/1ns
module timer_pin_source (
   input wire clk_i,
   output reg ext_pin_o,
   output reg cap_one_o,
   output reg cap_two_o
);
   initial begin
      ext_pin_o = 1'b0;
      cap_one_o = 1'b1;
      cap_two_o = 1'b1;
   end
   //////////////////////////////////////////////////
   // five cycles per level: active edges ten cycles apart
   task automatic toggle(input int n);
      repeat (n) begin
         @(posedge clk_i);
         ext_pin_o <= ~ext_pin_o;
         repeat (4) @(posedge clk_i);
      end
   endtask
   task automatic caps(input bit lvl);
      @(posedge clk_i);
      cap_one_o <= lvl;
      cap_two_o <= lvl;
      repeat (3) @(posedge clk_i);
   endtask
endmodule // timer_pin_source

// *** verification/timer16_counter_capture_tb.sv ***
`timescale 1ns/1ns
`include "timer16_consts.vh"
module timer16_counter_capture_tb;
   logic clk_i, rstn_i, halt_mode_i, global_irq_permit_i;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] resp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_irq_o;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire ext_pin, cap_one, cap_two;
   int mismatches, checks_done, cyc, seed, n, exp_cnt, lvl, hits;
   timer16_counter_capture dut_u (
      .clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ext_timer_clock_pin_i(ext_pin), .capture_pin_one_i(cap_one),
      .capture_pin_two_i(cap_two), .global_irq_permit_i(global_irq_permit_i),
      .halt_mode_i(halt_mode_i), .timer_irq_o(timer_irq_o)
   );
   timer_pin_source src_u (.clk_i(clk_i), .ext_pin_o(ext_pin), .cap_one_o(cap_one),
      .cap_two_o(cap_two));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   //////////////////////////////////////////////////
   task automatic check(input [31:0] seen, input [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input [7:0] a);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rc(input [7:0] a, input [31:0] e);
      rd(a);
      check(rv, e);
   endtask
   // counter runs for exactly k edges, then freezes again
   task automatic run(input int k);
      halt_mode_i <= 1'b0;
      repeat (k) @(posedge clk_i);
      halt_mode_i <= 1'b1;
   endtask
   task automatic finish_test;
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   //////////////////////////////////////////////////
   initial begin
      seed = 86;
      rstn_i = 1'b0;
      halt_mode_i = 1'b1;
      global_irq_permit_i = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      rc(`T16_ADDR_CNT_HI, 8'hFF);
      rc(`T16_ADDR_CNT_LO, 8'hFC);
      rc(`T16_ADDR_ACNT_HI, 8'hFF);
      rc(`T16_ADDR_ACNT_LO, 8'hFC);
      rd(8'h30);
      check(resp, 2'h2);
      wr(8'h30, 32'h0);
      check(resp, 2'h2);
      // 40 edges is a whole number of periods for every divider
      for (int s = 0; s < 3; s++) begin
         wr(`T16_ADDR_CTRL_TWO, s << 1);
         wr(`T16_ADDR_CNT_LO, 32'h0);
         run(40);
         exp_cnt = (16'hFFFC + 40 / (2 << s)) & 16'hFFFF;
         rc(`T16_ADDR_CNT_HI, exp_cnt >> 8);
         rc(`T16_ADDR_CNT_LO, exp_cnt & 8'hFF);
      end
      rc(`T16_ADDR_CNT_HI, exp_cnt >> 8);
      run(80);
      rc(`T16_ADDR_CNT_HI, (exp_cnt + 10) >> 8);
      rc(`T16_ADDR_CNT_LO, exp_cnt & 8'hFF);
      exp_cnt += 10;
      rc(`T16_ADDR_CNT_LO, exp_cnt & 8'hFF);
      wr(`T16_ADDR_CTRL_ONE, 32'h20);
      check(timer_irq_o, 1'b0);
      global_irq_permit_i <= 1'b1;
      @(posedge clk_i);
      check(timer_irq_o, 1'b1);
      rc(`T16_ADDR_STATUS, 8'h20);
      rc(`T16_ADDR_ACNT_LO, exp_cnt & 8'hFF);
      rc(`T16_ADDR_STATUS, 8'h20);
      rc(`T16_ADDR_CNT_LO, exp_cnt & 8'hFF);
      rc(`T16_ADDR_STATUS, 8'h00);
      check(timer_irq_o, 1'b0);
      // channel one on rising, channel two on falling; count moves between
      wr(`T16_ADDR_CTRL_ONE, 32'hA2);
      wr(`T16_ADDR_CTRL_TWO, 32'h00);
      src_u.caps(1'b0);
      run(16);
      src_u.caps(1'b1);
      rc(`T16_ADDR_STATUS, 8'h90);
      check(timer_irq_o, 1'b1);
      rc(`T16_ADDR_CAP1_HI, 8'h00);
      rc(`T16_ADDR_CAP1_LO, (exp_cnt + 8) & 8'hFF);
      rc(`T16_ADDR_CAP2_HI, 8'h00);
      rc(`T16_ADDR_CAP2_LO, exp_cnt & 8'hFF);
      rc(`T16_ADDR_STATUS, 8'h00);
      exp_cnt += 8;
      rc(`T16_ADDR_CAP1_HI, 8'h00);
      src_u.caps(1'b0);
      run(16);
      src_u.caps(1'b1);
      rc(`T16_ADDR_STATUS, 8'h10);
      rc(`T16_ADDR_CAP1_LO, exp_cnt & 8'hFF);
      rc(`T16_ADDR_CAP2_HI, 8'h00);
      rc(`T16_ADDR_CAP2_LO, exp_cnt & 8'hFF);
      // one-pulse operation leaves only channel two able to capture
      wr(`T16_ADDR_CTRL_TWO, 32'h10);
      src_u.caps(1'b0);
      src_u.caps(1'b1);
      rc(`T16_ADDR_STATUS, 8'h10);
      rc(`T16_ADDR_CAP1_LO, exp_cnt & 8'hFF);
      rc(`T16_ADDR_PINS, {ext_pin, cap_two, cap_one});
      // external clock: rising then falling, random transition count
      for (int e = 1; e >= 0; e--) begin
         lvl = ext_pin;
         n = 4 + ($random(seed) & 3);
         wr(`T16_ADDR_CTRL_TWO, 32'h6 | e);
         halt_mode_i <= 1'b0;
         wr(e ? `T16_ADDR_CNT_LO : `T16_ADDR_ACNT_LO, 32'h0);
         src_u.toggle(n);
         hits = (lvl == e) ? n / 2 : (n + 1) / 2;
         exp_cnt = (16'hFFFC + hits) & 16'hFFFF;
         rc(`T16_ADDR_CNT_HI, exp_cnt >> 8);
         rc(`T16_ADDR_CNT_LO, exp_cnt & 8'hFF);
      end
      finish_test();
   end
endmodule // timer16_counter_capture_tb
